// >>> lss_map.svh
`ifndef LSS_MAP_SVH
`define LSS_MAP_SVH

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define LSS_PIXELS 64
`define LSS_PTR_W 6
`define LSS_CNT_W 7
`define LSS_REC_W 7
`define LSS_FIFO_DEPTH 16

// ----------------------------------------
// Pulse numbers within one readout
// ----------------------------------------
`define LSS_PULSE_FIRST 7'h01
`define LSS_PULSE_LAST_PIXEL_SAMPLE_HOLD_SET 7'h01
`define LSS_PULSE_CLEAR 7'h02
`define LSS_PULSE_SNH_DROP 7'h3F
`define LSS_PULSE_LAST 7'h40

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LSS_RST_SNH 1'h0
`define LSS_RST_LAST_PIXEL_SAMPLE_HOLD 1'h0
`define LSS_RST_CLEAR_N 1'h0
`define LSS_RST_PTR 6'h00

`endif

// >>> lss_pkg.sv
`include "lss_map.svh"

package lss_pkg;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic {
    LSS_TRACK,
    LSS_READ
  } lss_state_e;

  // Record per clock: {pixel 1 tracking, pixel pointer}
  typedef logic [`LSS_REC_W-1:0] lss_rec_t;

endpackage : lss_pkg

// >>> lss_stream_if.sv
`timescale 1ns/100ps

interface lss_stream_if;
  import lss_pkg::*;

  logic valid;
  logic ready;
  lss_rec_t data;

  modport src
  (
    output valid,
    output data,
    input ready
  );

  modport snk
  (
    input valid,
    input data,
    output ready
  );

endinterface : lss_stream_if

// >>> lss_fifo.sv
`timescale 1ns/100ps
`include "lss_map.svh"

module lss_fifo
  import lss_pkg::*;
#(
  parameter int WIDTH = `LSS_REC_W,
  parameter int DEPTH = `LSS_FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Fill side
  lss_stream_if.snk wr,
  // Drain side
  lss_stream_if.src rd
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic out_valid;
  logic [WIDTH-1:0] out_data;

  // ----------------------------------------
  // Handshake decode
  // ----------------------------------------
  wire mem_full = (count == CW'(DEPTH));
  wire mem_empty = (count == '0);
  wire push = wr.valid && !mem_full;
  wire pop = !mem_empty && (!out_valid || rd.ready);
  wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);

  assign wr.ready = !mem_full;
  assign rd.valid = out_valid;
  assign rd.data = out_data;

  // ----------------------------------------
  // Storage and pointers
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= wr.data;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      count <= next_count;
    end
  end

  // Registered head so the drain side sees flip-flop outputs
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      out_valid <= pop || (out_valid && !rd.ready);
      out_data <= pop ? mem[rd_ptr] : out_data;
    end
  end

endmodule : lss_fifo

// >>> lss_readout.sv
`timescale 1ns/100ps
`include "lss_map.svh"

module lss_readout
  import lss_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Controller inputs
  input wire logic start_integration_in_i,
  input wire logic shutter_hold_in_i,
  // Analogue switch controls
  output logic sample_hold_select_o,
  output logic last_pixel_sample_hold_o,
  output logic integrator_clear_n_o,
  output logic photodiode_connect_o,
  output logic [`LSS_PTR_W-1:0] analog_out_sel_o,
  output logic analog_out_track_o,
  // Pixel record stream to the capture side
  output logic pixel_valid_o,
  output logic [`LSS_REC_W-1:0] pixel_data_o,
  input wire logic pixel_ready_i,
  output logic pixel_fifo_ready_o
);

  lss_state_e state;
  lss_state_e next_state;
  logic [`LSS_CNT_W-1:0] pulse;
  logic rec_valid;

  lss_stream_if fill_if ();
  lss_stream_if drain_if ();

  // ----------------------------------------
  // Sequencer decode
  // ----------------------------------------
  wire start = start_integration_in_i;
  wire in_read = (state == LSS_READ);
  wire restart = start && in_read;
  wire at_last_pixel_sample_hold_set = in_read && (pulse == `LSS_PULSE_LAST_PIXEL_SAMPLE_HOLD_SET);
  wire at_clear = in_read && (pulse == `LSS_PULSE_CLEAR);
  wire at_snh_drop = in_read && (pulse == `LSS_PULSE_SNH_DROP);
  wire at_last = in_read && (pulse == `LSS_PULSE_LAST);
  wire [`LSS_CNT_W-1:0] next_pulse = start ? `LSS_PULSE_FIRST : `LSS_CNT_W'(pulse + 1'b1);
  wire [`LSS_PTR_W-1:0] read_ptr = pulse[`LSS_PTR_W-1:0];
  // Outside a run the pointer must not follow the stale pulse count
  wire park_ptr = at_last || !in_read;
  wire [`LSS_PTR_W-1:0] next_ptr = (start || park_ptr) ? `LSS_RST_PTR : read_ptr;
  wire next_track = !start && (at_last || !in_read);
  // A restart leaves the holds set so the old held values stay put
  wire next_snh = start || (sample_hold_select_o && !at_snh_drop);
  wire keep_last_pixel_sample_hold = last_pixel_sample_hold_o && (restart || !at_last);
  wire next_last_pixel_sample_hold = (at_last_pixel_sample_hold_set && !start) || keep_last_pixel_sample_hold;

  always_comb
  begin
    next_state = state;
    case (state)
      LSS_TRACK:
      begin
        if (start)
        begin
          next_state = LSS_READ;
        end
      end
      LSS_READ:
      begin
        if (at_last && !start)
        begin
          next_state = LSS_TRACK;
        end
      end
      default:
      begin
        next_state = LSS_TRACK;
      end
    endcase
  end

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state <= LSS_TRACK;
      pulse <= '0;
    end
    else
    begin
      state <= next_state;
      pulse <= (start || in_read) ? next_pulse : pulse;
    end
  end

  // ----------------------------------------
  // Switch controls
  // ----------------------------------------
  // Clear is held low through reset so all capacitors start discharged
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sample_hold_select_o <= `LSS_RST_SNH;
    end
    else
    begin
      sample_hold_select_o <= next_snh;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      last_pixel_sample_hold_o <= `LSS_RST_LAST_PIXEL_SAMPLE_HOLD;
    end
    else
    begin
      last_pixel_sample_hold_o <= next_last_pixel_sample_hold;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      integrator_clear_n_o <= `LSS_RST_CLEAR_N;
    end
    else
    begin
      integrator_clear_n_o <= !(at_clear && !start);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      photodiode_connect_o <= 1'b0;
    end
    else
    begin
      photodiode_connect_o <= !shutter_hold_in_i;
    end
  end

  // ----------------------------------------
  // Output multiplexer
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      analog_out_sel_o <= `LSS_RST_PTR;
    end
    else
    begin
      analog_out_sel_o <= next_ptr;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      analog_out_track_o <= 1'b1;
    end
    else
    begin
      analog_out_track_o <= next_track;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rec_valid <= 1'b0;
    end
    else
    begin
      rec_valid <= 1'b1;
    end
  end

  // ----------------------------------------
  // Record stream
  // ----------------------------------------
  // The analogue sequence cannot pause, so a full FIFO drops records;
  // the capture side watches pixel_fifo_ready_o to notice that.
  assign fill_if.valid = rec_valid;
  assign fill_if.data = {analog_out_track_o, analog_out_sel_o};
  assign drain_if.ready = pixel_ready_i;
  assign pixel_valid_o = drain_if.valid;
  assign pixel_data_o = drain_if.data;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pixel_fifo_ready_o <= 1'b1;
    end
    else
    begin
      pixel_fifo_ready_o <= fill_if.ready;
    end
  end

  lss_fifo #(
    .WIDTH(`LSS_REC_W),
    .DEPTH(`LSS_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .wr(fill_if.snk),
    .rd(drain_if.src)
  );

endmodule : lss_readout

// >>> lss_readout_assertions.sv
`timescale 1ns/100ps

module lss_readout_assertions
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Inputs
  input wire logic start_integration_in_i,
  input wire logic shutter_hold_in_i,
  input wire logic pixel_ready_i,
  // Outputs
  input wire logic sample_hold_select_o,
  input wire logic last_pixel_sample_hold_o,
  input wire logic integrator_clear_n_o,
  input wire logic photodiode_connect_o,
  input wire logic [5:0] analog_out_sel_o,
  input wire logic analog_out_track_o,
  input wire logic pixel_valid_o,
  input wire logic [6:0] pixel_data_o
);
  // Pulses since last start; parks at 7F so idle reads as a finished run
  logic [6:0] since;
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      since <= 7'h7F;
    else if (start_integration_in_i)
      since <= 7'h00;
    else if (since != 7'h7F)
      since <= since + 7'h01;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_last_set;
    $rose(sample_hold_select_o) && !start_integration_in_i |=> last_pixel_sample_hold_o;
  endproperty
  a_last_set: assert property (p_last_set) else $error("late pixel 64 hold");
  property p_hold;
    since < 7'h3F |-> sample_hold_select_o;
  endproperty
  a_hold: assert property (p_hold) else $error("hold lost in run");
  property p_drop;
    since == 7'h3F && !start_integration_in_i |->
      !sample_hold_select_o && last_pixel_sample_hold_o ##1 !last_pixel_sample_hold_o;
  endproperty
  a_drop: assert property (p_drop) else $error("wrong hold release");
  property p_sel;
    since < 7'h40 |-> analog_out_sel_o == since[5:0] && !analog_out_track_o;
  endproperty
  a_sel: assert property (p_sel) else $error("wrong pixel on output");
  property p_park;
    since > 7'h3F |-> analog_out_track_o && analog_out_sel_o == 6'h00;
  endproperty
  a_park: assert property (p_park) else $error("no tracking after run");
  property p_clear;
    since == 7'h02 |-> !integrator_clear_n_o ##1 integrator_clear_n_o;
  endproperty
  a_clear: assert property (p_clear) else $error("bad clear pulse");
  property p_shutter;
    1'b1 |=> photodiode_connect_o == !$past(shutter_hold_in_i);
  endproperty
  a_shutter: assert property (p_shutter) else $error("bad connect");
  property p_stream;
    pixel_valid_o && !pixel_ready_i |=> pixel_valid_o && $stable(pixel_data_o);
  endproperty
  a_stream: assert property (p_stream) else $error("record not held");
endmodule : lss_readout_assertions

// >>> lss_ctrl_model.sv
`timescale 1ns/100ps

module lss_ctrl_model
(
  // Clock
  input wire logic clk_i,
  // Controller drive
  output logic start_integration_in_o,
  output logic shutter_hold_in_o
);
  initial
  begin
    start_integration_in_o = 1'h0;
    shutter_hold_in_o = 1'h0;
  end

  // Changed at falling edges so start is stable around the rising edge
  task automatic start_run();
    @(negedge clk_i);
    start_integration_in_o = 1'h1;
    @(negedge clk_i);
    start_integration_in_o = 1'h0;
  endtask : start_run

  task automatic set_shutter(input logic v);
    @(negedge clk_i);
    shutter_hold_in_o = v;
  endtask : set_shutter
endmodule : lss_ctrl_model

// >>> lss_readout_tb.sv
`timescale 1ns/100ps

module lss_readout_tb;
  import lss_pkg::*;
  logic clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic ready = 1'h0;
  logic start, shut, sample_hold_select, last_pixel_sample_hold, clr_n, conn, trk, pv, fr;
  logic [5:0] sel;
  logic [6:0] pd;
  int n_mismatch = 0;
  int total_checks = 0;

  always #20 clk_i = ~clk_i;

  lss_ctrl_model lss_ctrl_model_i (.clk_i, .start_integration_in_o(start),
    .shutter_hold_in_o(shut));
  lss_readout lss_readout_i (.clk_i, .reset_n_i, .start_integration_in_i(start),
    .shutter_hold_in_i(shut), .sample_hold_select_o(sample_hold_select), .last_pixel_sample_hold_o(last_pixel_sample_hold),
    .integrator_clear_n_o(clr_n), .photodiode_connect_o(conn), .analog_out_sel_o(sel),
    .analog_out_track_o(trk), .pixel_valid_o(pv), .pixel_data_o(pd), .pixel_ready_i(ready),
    .pixel_fifo_ready_o(fr));

  task automatic check(input string what, input logic [6:0] exp, input logic [6:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tally_and_finish();
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic s_reset();
    repeat (2) @(negedge clk_i);
    check("reset", 7'h04, {sample_hold_select, last_pixel_sample_hold, clr_n, conn, trk, sel[1:0]});
    @(negedge clk_i);
    reset_n_i = 1'h1;
    @(negedge clk_i);
    check("clear_n", 7'h01, 7'(clr_n));
  endtask : s_reset

  // Capture side stalls first, so records are dropped before the drain
  task automatic s_fifo();
    int n;
    repeat (20) @(negedge clk_i);
    check("fifo_full", 7'h01, {5'h00, fr, pv});
    ready = 1'h1;
    lss_ctrl_model_i.start_run();
    for (n = 0; n < 40 && pd !== 7'h00; n++)
      @(negedge clk_i);
    if (n == 40)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    for (n = 1; n < 20; n++)
    begin
      @(negedge clk_i);
      check("record", 7'(n), pd);
    end
    repeat (50) @(negedge clk_i);
  endtask : s_fifo

  task automatic s_run();
    int n;
    lss_ctrl_model_i.start_run();
    check("hold", 7'h02, 7'({sample_hold_select, last_pixel_sample_hold}));
    for (n = 0; n < 64; n++)
    begin
      check("sel", 7'(n), 7'(sel));
      check("clear_n", 7'(n != 2), 7'(clr_n));
      check("hold_lo", 7'(n < 63), 7'(sample_hold_select));
      check("hold_hi", 7'(n > 0), 7'(last_pixel_sample_hold));
      @(negedge clk_i);
    end
    check("park", 7'h40, {trk, sel});
    check("sample", 7'h00, 7'({sample_hold_select, last_pixel_sample_hold}));
    @(negedge clk_i);
    check("park_hold", 7'h40, {trk, sel});
  endtask : s_run

  task automatic s_restart();
    lss_ctrl_model_i.start_run();
    repeat (29) @(negedge clk_i);
    lss_ctrl_model_i.start_run();
    check("restart", 7'h60, {sample_hold_select, last_pixel_sample_hold, trk, sel[3:0]});
    @(negedge clk_i);
    check("restart_sel", 7'h01, 7'(sel));
    repeat (70) @(negedge clk_i);
  endtask : s_restart

  task automatic s_shutter();
    lss_ctrl_model_i.set_shutter(1'h1);
    @(negedge clk_i);
    check("connect", 7'h00, 7'(conn));
    lss_ctrl_model_i.set_shutter(1'h0);
    @(negedge clk_i);
    check("connect", 7'h01, 7'(conn));
  endtask : s_shutter

  initial
  begin
    s_reset();
    s_fifo();
    s_run();
    s_restart();
    s_shutter();
    tally_and_finish();
  end
endmodule : lss_readout_tb

bind lss_readout lss_readout_assertions lss_readout_assertions_i (.clk_i, .reset_n_i,
  .start_integration_in_i, .shutter_hold_in_i, .pixel_ready_i, .sample_hold_select_o,
  .last_pixel_sample_hold_o, .integrator_clear_n_o, .photodiode_connect_o,
  .analog_out_sel_o, .analog_out_track_o, .pixel_valid_o, .pixel_data_o);
